// ==== ipr_pkg.sv ====
// shared constants, register map and helpers for the serial register set
package ipr_pkg;
   // clocking
   localparam int CLK_MHZ = 250;
   localparam int SCL_KHZ = 1000;
   localparam int QTR_CYC = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
   // device register pointers
   localparam logic [7:0] REG_DATA_LEN = 8'h81;
   localparam logic [7:0] REG_STATE    = 8'h82;
   localparam logic [7:0] REG_ADDR     = 8'h83;
   localparam logic [7:0] REG_SCL      = 8'h84;
   localparam logic [7:0] REG_GUARD    = 8'h85;
   localparam logic [7:0] REG_TMO      = 8'h86;
   // window length limits and packet overhead
   localparam logic [15:0] LEN_MIN  = 16'h0010;
   localparam logic [15:0] LEN_MAX  = 16'hffff;
   localparam logic [15:0] LEN_CAP  = 16'h0115;
   localparam logic [15:0] PKT_OVH  = 16'h0005;
   localparam logic [31:0] UNSUP    = 32'h0fff_ffff;
   // address register layout
   localparam logic [6:0] ADDR_RST    = 7'h30;
   localparam int         PERSIST_BIT = 15;
   // status word layout
   localparam int         ST_BUSY  = 31;
   localparam int         ST_RDY   = 30;
   localparam logic [4:0] DEV_FEAT = 5'h04;
   // bus speed modes and their top clock in kHz
   localparam logic [2:0]  MODE_SM   = 3'h1;
   localparam logic [2:0]  MODE_FM   = 3'h2;
   localparam logic [2:0]  MODE_SMFM = 3'h3;
   localparam logic [2:0]  MODE_FMP  = 3'h4;
   localparam logic [31:0] KHZ_SM    = 32'h0000_0064;
   localparam logic [31:0] KHZ_FM    = 32'h0000_0190;
   localparam logic [31:0] KHZ_FMP   = 32'h0000_03e8;
   localparam logic [31:0] TMO_MS    = 32'h0000_000a;
   localparam logic [31:0] GUARD_DEF = 32'h0000_0000;
   // controller register offsets
   localparam logic [7:0] H_CTRL  = 8'h00;
   localparam logic [7:0] H_WDATA = 8'h04;
   localparam logic [7:0] H_RDATA = 8'h08;
   localparam logic [7:0] H_STAT  = 8'h0c;
   localparam logic [7:0] H_ISTAT = 8'h10;
   localparam logic [7:0] H_IMASK = 8'h14;
   localparam logic [7:0] H_PKT   = 8'h18;
   localparam int         GO_BIT  = 31;
   localparam int         RD_BIT  = 16;

   // bytes carried by a register
   function automatic logic [2:0] reg_bytes(input logic [7:0] p);
      if (p == REG_DATA_LEN || p == REG_ADDR) begin
         return 3'h2;
      end else if (p >= REG_STATE && p <= REG_TMO) begin
         return 3'h4;
      end
      return 3'h1;
   endfunction
endpackage

// ==== ipr_if.sv ====
// two-wire serial link between controller and device
interface ipr_if;
   logic scl_o;
   logic scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;

   // open drain: a driver only pulls low
   assign scl = ~(scl_oe & ~scl_o);
   assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

   modport dev  (input scl, sda, output s_sda_o, s_sda_oe);
   modport host (input sda, output scl_o, scl_oe, m_sda_o, m_sda_oe);
endinterface

// ==== ipr_sync.sv ====
// two-stage pin synchroniser with edge pulses
module ipr_sync (
   // system
   input  wire logic pclk,
   input  wire logic presetn,
   // pin and result
   input  wire logic pin,
   output logic      lvl,
   output logic      rise,
   output logic      fall
);
   logic meta_q;
   logic lvl_q;
   logic old_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 1'b1;
         lvl_q  <= 1'b1;
         old_q  <= 1'b1;
      end else begin
         meta_q <= pin;
         lvl_q  <= meta_q;
         old_q  <= lvl_q;
      end
   end

   assign lvl  = lvl_q;
   assign rise = lvl_q & ~old_q;
   assign fall = ~lvl_q & old_q;
endmodule

// ==== ipr_dev.sv ====
// device end: protocol register set behind the serial slave
// Behaviour
// - window length accepted only 0x0010..0xFFFF
// - new length applies from next access
// - unsupported length loads device maximum
// - controller reads length back after write
// - packet size equals window length minus 5
// - status top byte: features, busy, ready
// - status low half: response length
// - slave address defaults to 0x30
// - new address answers from next access
// - address bits 6:0, bit15 stores persistently
// - clock register reports top SCL kHz
// - top clock follows selected speed mode
// - fast mode top clock within 50..400
// - unsupported register reads 0xFFFFFFF, use defaults
// - bit31 busy, bit30 response ready
// - bit15 clear: address lost at reset
module ipr_dev (
   // system
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        por_n,
   // serial link
   ipr_if.dev               bus,
   // device core
   input  wire logic        busy,
   input  wire logic        resp_ready,
   input  wire logic [15:0] resp_len,
   input  wire logic [2:0]  bus_mode,
   output logic      [15:0] window_len,
   output logic      [15:0] max_packet,
   output logic      [6:0]  own_addr
);
   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_RACK
   } ipr_dst_t;

   ipr_dst_t    st_q;
   logic [3:0]  cnt_q;
   logic [7:0]  sh_q;
   logic [7:0]  tx_q;
   logic        rw_q;
   logic        sda_oe_q;
   logic [2:0]  ridx_q;
   logic [7:0]  ptr_q;
   logic        have_ptr_q;
   logic [2:0]  widx_q;
   logic [31:0] wbuf_q;
   logic [6:0]  persist_q;
   logic        load_q;
   logic [31:0] khz_q;
   logic        scl_s;
   logic        scl_r;
   logic        scl_f;
   logic        sda_s;
   logic        sda_r;
   logic        sda_f;
   logic        start;
   logic        stop;
   logic        byte_in;
   logic        commit;
   logic [2:0]  nb;
   logic [2:0]  pos;
   logic [31:0] rd_word;
   logic [7:0]  rd_byte;

   ipr_sync u_scl (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (bus.scl),
      .lvl     (scl_s),
      .rise    (scl_r),
      .fall    (scl_f)
   );

   ipr_sync u_sda (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (bus.sda),
      .lvl     (sda_s),
      .rise    (sda_r),
      .fall    (sda_f)
   );

   assign start   = scl_s & sda_f;
   assign stop    = scl_s & sda_r;
   assign byte_in = scl_f && cnt_q == 4'h8 && !start && !stop;
   assign nb      = ipr_pkg::reg_bytes(ptr_q);
   assign commit  = (start | stop) && have_ptr_q && widx_q == nb;

   assign bus.s_sda_o  = 1'b0;
   assign bus.s_sda_oe = sda_oe_q;

   // read view of the selected register
   always_comb begin
      unique case (ptr_q)
         ipr_pkg::REG_DATA_LEN: rd_word = {16'h0000, window_len};
         ipr_pkg::REG_STATE: rd_word = {busy, resp_ready, 2'b00,
                                        ipr_pkg::DEV_FEAT, 7'h00, resp_len};
         ipr_pkg::REG_ADDR:  rd_word = 32'h0000_0000;
         ipr_pkg::REG_SCL:   rd_word = khz_q;
         ipr_pkg::REG_GUARD: rd_word = ipr_pkg::UNSUP;
         ipr_pkg::REG_TMO:   rd_word = ipr_pkg::TMO_MS;
         default:            rd_word = 32'hffff_ffff;
      endcase
      pos = nb - 3'h1 - ridx_q;
      if (ridx_q >= nb) begin
         rd_byte = 8'hff;
      end else begin
         rd_byte = 8'(rd_word >> {pos[1:0], 3'b000});
      end
   end

   // bit and byte sequencing on the link
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q     <= S_IDLE;
         cnt_q    <= 4'h0;
         sh_q     <= 8'h00;
         tx_q     <= 8'h00;
         rw_q     <= 1'b0;
         sda_oe_q <= 1'b0;
         ridx_q   <= 3'h0;
      end else if (start) begin
         st_q     <= S_ADDR;
         cnt_q    <= 4'h0;
         sda_oe_q <= 1'b0;
         ridx_q   <= 3'h0;
      end else if (stop) begin
         st_q     <= S_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         unique case (st_q)
            S_IDLE: begin
            end
            S_ADDR, S_WR: begin
               if (scl_r) begin
                  sh_q  <= {sh_q[6:0], sda_s};
                  cnt_q <= cnt_q + 4'h1;
               end
               if (byte_in) begin
                  cnt_q <= 4'h0;
                  if (st_q == S_WR) begin
                     st_q     <= S_WACK;
                     sda_oe_q <= 1'b1;
                  end else if (sh_q[7:1] == own_addr) begin
                     st_q     <= S_AACK;
                     sda_oe_q <= 1'b1;
                     rw_q     <= sh_q[0];
                  end else begin
                     st_q <= S_IDLE;
                  end
               end
            end
            S_AACK, S_RACK: begin
               if (st_q == S_RACK && scl_r && sda_s) begin
                  st_q <= S_IDLE;
               end else if (scl_f && (st_q == S_RACK || rw_q)) begin
                  st_q     <= S_RD;
                  tx_q     <= rd_byte;
                  sda_oe_q <= ~rd_byte[7];
               end else if (scl_f) begin
                  st_q     <= S_WR;
                  sda_oe_q <= 1'b0;
               end
            end
            S_WACK: begin
               if (scl_f) begin
                  st_q     <= S_WR;
                  sda_oe_q <= 1'b0;
               end
            end
            S_RD: begin
               if (scl_r) begin
                  cnt_q <= cnt_q + 4'h1;
               end
               if (scl_f && cnt_q == 4'h8) begin
                  st_q     <= S_RACK;
                  cnt_q    <= 4'h0;
                  sda_oe_q <= 1'b0;
                  ridx_q   <= ridx_q + 3'h1;
               end else if (scl_f) begin
                  tx_q     <= {tx_q[6:0], 1'b0};
                  sda_oe_q <= ~tx_q[6];
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_q      <= 8'h00;
         have_ptr_q <= 1'b0;
         widx_q     <= 3'h0;
         wbuf_q     <= 32'h0000_0000;
      end else if (start) begin
         have_ptr_q <= 1'b0;
         widx_q     <= 3'h0;
      end else if (byte_in && st_q == S_WR && !have_ptr_q) begin
         ptr_q      <= sh_q;
         have_ptr_q <= 1'b1;
      end else if (byte_in && st_q == S_WR && widx_q != 3'h7) begin
         wbuf_q <= {wbuf_q[23:0], sh_q};
         widx_q <= widx_q + 3'h1;
      end
   end

   // window length and derived packet size
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         window_len <= ipr_pkg::LEN_CAP;
         max_packet <= ipr_pkg::LEN_CAP - ipr_pkg::PKT_OVH;
      end else begin
         if (commit && ptr_q == ipr_pkg::REG_DATA_LEN &&
             wbuf_q[15:0] >= ipr_pkg::LEN_MIN) begin
            window_len <= (wbuf_q[15:0] > ipr_pkg::LEN_CAP) ?
                          ipr_pkg::LEN_CAP : wbuf_q[15:0];
         end
         max_packet <= window_len - ipr_pkg::PKT_OVH;
      end
   end

   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         persist_q <= ipr_pkg::ADDR_RST;
      end else if (commit && ptr_q == ipr_pkg::REG_ADDR &&
                   wbuf_q[ipr_pkg::PERSIST_BIT]) begin
         persist_q <= wbuf_q[6:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         own_addr <= ipr_pkg::ADDR_RST;
         load_q   <= 1'b1;
      end else if (load_q) begin
         own_addr <= persist_q;
         load_q   <= 1'b0;
      end else if (commit && ptr_q == ipr_pkg::REG_ADDR) begin
         own_addr <= wbuf_q[6:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         khz_q <= ipr_pkg::KHZ_FM;
      end else begin
         unique case (bus_mode)
            ipr_pkg::MODE_SM:                   khz_q <= ipr_pkg::KHZ_SM;
            ipr_pkg::MODE_FM, ipr_pkg::MODE_SMFM: khz_q <= ipr_pkg::KHZ_FM;
            ipr_pkg::MODE_FMP:                  khz_q <= ipr_pkg::KHZ_FMP;
            default:                            khz_q <= khz_q;
         endcase
      end
   end
endmodule

// ==== ipr_host.sv ====
// controller end: APB-programmed serial master for the register set
//
// Register access over APB was left to the implementer.
module ipr_host (
   // system
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   // serial link
   ipr_if.host              bus
);
   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} ipr_hst_t;

   ipr_hst_t    st_q;
   logic [7:0]  div_q;
   logic [1:0]  q_q;
   logic [3:0]  bit_q;
   logic [2:0]  idx_q;
   logic [7:0]  sh_q;
   logic [7:0]  rx_q;
   logic        ack_q;
   logic        rd_q;
   logic        verify_q;
   logic        scl_oe_q;
   logic        sda_oe_q;
   logic [7:0]  ptr_q;
   logic [6:0]  addr_q;
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   logic        nack_q;
   logic        unsup_q;
   logic        ref_q;
   logic [15:0] pkt_q;
   logic [2:0]  ist_q;
   logic [2:0]  imsk_q;
   logic        tick;
   logic        sda_s;
   logic        fin;
   logic        go;
   logic        bad;
   logic        is_tx;
   logic        last;
   logic        bend;
   logic        more;
   logic        ev_done;
   logic        ev_nack;
   logic [2:0]  nb;
   logic [31:0] rmux;

   // byte sent at a given stream position
   function automatic logic [7:0] hbyte(input logic [2:0] i, input logic [2:0] n,
                                        input logic r, input logic [31:0] w);
      logic [2:0] p;
      p = n - 3'h1 - (i - 3'h2);
      if (i == 3'h0) begin
         return {addr_q, 1'b0};
      end else if (i == 3'h1) begin
         return ptr_q;
      end else if (r) begin
         return {addr_q, 1'b1};
      end
      return 8'(w >> {p[1:0], 3'b000});
   endfunction

   ipr_sync u_sda (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (bus.sda),
      .lvl     (sda_s),
      .rise    (),
      .fall    ()
   );

   assign nb    = ipr_pkg::reg_bytes(ptr_q);
   assign tick  = div_q == 8'(ipr_pkg::QTR_CYC - 1);
   assign fin   = psel & penable & pready;
   assign go    = fin && pwrite && paddr == ipr_pkg::H_CTRL &&
                  pwdata[ipr_pkg::GO_BIT] && st_q == H_IDLE;
   assign bad   = !pwdata[ipr_pkg::RD_BIT] && pwdata[7:0] == ipr_pkg::REG_DATA_LEN &&
                  (wdata_q[15:0] < ipr_pkg::LEN_MIN || wdata_q[31:16] != 16'h0000);
   assign is_tx = !(rd_q && idx_q >= 3'h3);
   assign last  = rd_q ? idx_q == nb + 3'h2 : idx_q == nb + 3'h1;
   assign bend  = st_q == H_BIT && tick && q_q == 2'h3 && bit_q == 4'h8;
   assign ev_nack = bend && is_tx && ack_q;
   // read length back after writing it
   assign more  = !rd_q && !nack_q && ptr_q == ipr_pkg::REG_DATA_LEN;
   assign ev_done = st_q == H_STOP && tick && q_q == 2'h3 && !more;

   assign bus.scl_o    = 1'b0;
   assign bus.m_sda_o  = 1'b0;
   assign bus.scl_oe   = scl_oe_q;
   assign bus.m_sda_oe = sda_oe_q;

   // quarter-bit enable divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 8'h00;
      end else begin
         div_q <= tick ? 8'h00 : div_q + 8'h01;
      end
   end

   // bus sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= H_IDLE;
         q_q <= 2'h0;
         bit_q <= 4'h0;
         idx_q <= 3'h0;
         sh_q <= 8'h00;
         rx_q <= 8'h00;
         ack_q <= 1'b0;
         rd_q <= 1'b0;
         verify_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (go && !bad) begin
         st_q <= H_START;
         q_q <= 2'h0;
         idx_q <= 3'h0;
         rd_q <= pwdata[ipr_pkg::RD_BIT];
         verify_q <= 1'b0;
      end else if (tick && st_q != H_IDLE) begin
         q_q <= q_q + 2'h1;
         unique case (st_q)
            H_START: begin
               sda_oe_q <= q_q == 2'h2 || (q_q == 2'h3);
               scl_oe_q <= q_q == 2'h0 || (q_q == 2'h3);
               if (q_q == 2'h3) begin
                  st_q <= H_BIT;
                  bit_q <= 4'h0;
                  sh_q <= hbyte(idx_q, nb, rd_q, wdata_q);
               end
            end
            H_BIT: begin
               unique case (q_q)
                  2'h0: sda_oe_q <= bit_q == 4'h8 ? !is_tx && !last : is_tx && !sh_q[7];
                  2'h1: scl_oe_q <= 1'b0;
                  2'h2: begin
                     if (bit_q == 4'h8) begin
                        ack_q <= sda_s;
                     end else begin
                        rx_q <= {rx_q[6:0], sda_s};
                     end
                  end
                  2'h3: begin
                     scl_oe_q <= 1'b1;
                     sh_q <= {sh_q[6:0], 1'b0};
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        idx_q <= idx_q + 3'h1;
                        sh_q <= hbyte(idx_q + 3'h1, nb, rd_q, wdata_q);
                        if (ev_nack || last) begin
                           st_q <= H_STOP;
                        end else if (rd_q && idx_q == 3'h1) begin
                           st_q <= H_START;
                        end
                     end
                  end
               endcase
            end
            H_STOP: begin
               sda_oe_q <= q_q != 2'h2;
               scl_oe_q <= q_q == 2'h0;
               if (q_q == 2'h3) begin
                  sda_oe_q <= 1'b0;
                  st_q <= more ? H_START : H_IDLE;
                  rd_q <= more;
                  verify_q <= more;
                  idx_q <= 3'h0;
               end
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   // transfer results and flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
         nack_q <= 1'b0;
         unsup_q <= 1'b0;
         ref_q <= 1'b0;
         pkt_q <= 16'h0000;
      end else if (go) begin
         rdata_q <= 32'h0000_0000;
         nack_q <= 1'b0;
         unsup_q <= 1'b0;
         ref_q <= bad;
      end else begin
         if (bend && !is_tx) begin
            rdata_q <= {rdata_q[23:0], rx_q};
         end
         if (ev_nack) begin
            nack_q <= 1'b1;
         end
         if (ev_done && rd_q && !nack_q) begin
            if (rdata_q == ipr_pkg::UNSUP) begin
               unsup_q <= 1'b1;
               rdata_q <= ptr_q == ipr_pkg::REG_TMO ? ipr_pkg::TMO_MS : ipr_pkg::GUARD_DEF;
            end
            if (ptr_q == ipr_pkg::REG_DATA_LEN) begin
               pkt_q <= rdata_q[15:0] - ipr_pkg::PKT_OVH;
            end
         end
      end
   end

   // programmed request fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_q <= 8'h00;
         addr_q <= ipr_pkg::ADDR_RST;
         wdata_q <= 32'h0000_0000;
         imsk_q <= 3'h0;
      end else if (fin && pwrite) begin
         if (go) begin
            ptr_q <= pwdata[7:0];
            addr_q <= pwdata[14:8];
         end
         if (paddr == ipr_pkg::H_WDATA) begin
            wdata_q <= pwdata;
         end
         if (paddr == ipr_pkg::H_IMASK) begin
            imsk_q <= pwdata[2:0];
         end
      end
   end

   // sticky events, read clears, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_q <= 3'h0;
         irq <= 1'b0;
      end else begin
         ist_q <= (fin && !pwrite && paddr == ipr_pkg::H_ISTAT ? 3'h0 : ist_q) |
                  {go && bad, ev_nack, ev_done};
         irq <= |(ist_q & imsk_q);
      end
   end

   always_comb begin
      unique case (paddr)
         ipr_pkg::H_CTRL:  rmux = {15'h0000, rd_q, 1'b0, addr_q, ptr_q};
         ipr_pkg::H_WDATA: rmux = wdata_q;
         ipr_pkg::H_RDATA: rmux = rdata_q;
         ipr_pkg::H_STAT:  rmux = {27'h0, verify_q, ref_q, unsup_q, nack_q,
                                   st_q != H_IDLE};
         ipr_pkg::H_ISTAT: rmux = {29'h0, ist_q};
         ipr_pkg::H_IMASK: rmux = {29'h0, imsk_q};
         ipr_pkg::H_PKT:   rmux = {16'h0000, pkt_q};
         default:          rmux = 32'h0000_0000;
      endcase
   end

   // one wait state per access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & (paddr > ipr_pkg::H_PKT || paddr[1:0] != 2'h0);
         prdata <= rmux;
      end
   end
endmodule

// ==== ipr_assertions.sv ====
// link and device output checks for the serial register set
module ipr_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        scl,
   input wire logic        s_sda_oe,
   input wire logic [15:0] window_len,
   input wire logic [15:0] max_packet,
   input wire logic [6:0]  own_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_PKT: assert property (1 |=> max_packet == $past(window_len) - 16'h0005)
      else $error("packet size differs from window minus five");
   AST_LEN_MIN: assert property (window_len >= 16'h0010)
      else $error("window length below minimum");
   AST_LEN_CAP: assert property (window_len <= 16'h0115)
      else $error("window length above device maximum");
   AST_LEN_SCL: assert property ($changed(window_len) |-> scl)
      else $error("window length changed inside a byte");
   AST_ADDR_SCL: assert property ($changed(own_addr) |-> scl)
      else $error("address changed inside a byte");
   AST_ADDR_RST: assert property ($rose(presetn) |-> own_addr == 7'h30)
      else $error("address reset value wrong");
   AST_SDA_SCL: assert property ($changed(s_sda_oe) |-> !scl)
      else $error("device moved data line while clock high");
   AST_SDA_HOLD: assert property ($rose(s_sda_oe) |=> s_sda_oe [*8])
      else $error("device data pull too short");
endmodule

// ==== ipr_test.sv ====
// self-checking bench: controller and device joined over the serial link
module ipr_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, irq;
   logic        busy, resp_ready, err;
   logic [2:0]  bus_mode;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] resp_len, window_len, max_packet;
   logic [6:0]  own_addr;
   int          fail_count, compares;
   ipr_if bif ();
   ipr_host u_ipr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .bus(bif.host));
   ipr_dev u_ipr_dev (.pclk(pclk), .presetn(presetn), .por_n(por_n), .bus(bif.dev),
      .busy(busy), .resp_ready(resp_ready), .resp_len(resp_len), .bus_mode(bus_mode),
      .window_len(window_len), .max_packet(max_packet), .own_addr(own_addr));
   ipr_assertions u_ipr_assertions (.pclk(pclk), .presetn(presetn), .scl(bif.scl),
      .s_sda_oe(bif.s_sda_oe), .window_len(window_len), .max_packet(max_packet),
      .own_addr(own_addr));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // one serial transfer, then fetch the read data
   task automatic op(input logic [7:0] p, input logic r, input logic [6:0] sa,
                     input logic [31:0] d);
      apb(1'b1, ipr_pkg::H_WDATA, d);
      apb(1'b1, ipr_pkg::H_CTRL, {1'b1, 14'h0000, r, 1'b0, sa, p});
      do apb(1'b0, ipr_pkg::H_STAT, 32'h0); while (rd[0] !== 1'b0);
      apb(1'b0, ipr_pkg::H_RDATA, 32'h0);
   endtask
   task automatic final_report;
      $display("mismatches %0d of %0d compares", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      repeat (100000) @(posedge pclk);
      fail_count++;
      final_report();
   end
   initial begin
      {presetn, por_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {busy, resp_ready, resp_len} = {2'b11, 16'h1234};
      bus_mode = ipr_pkg::MODE_FMP;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      por_n   <= 1'b1;
      apb(1'b0, 8'h1c, 32'h0);
      chk("unmapped", rd, 32'h0);
      chk("slverr", {31'h0, err}, 32'h1);
      apb(1'b1, ipr_pkg::H_IMASK, 32'h7);
      op(ipr_pkg::REG_DATA_LEN, 1'b0, 7'h30, 32'h40);
      chk("readback", rd, 32'h40);
      chk("window", {16'h0, window_len}, 32'h40);
      chk("irq", {31'h0, irq}, 32'h1);
      apb(1'b0, ipr_pkg::H_PKT, 32'h0);
      chk("pkt", rd, 32'h3b);
      apb(1'b0, ipr_pkg::H_ISTAT, 32'h0);
      chk("istat", rd, 32'h1);
      chk("slverr ok", {31'h0, err}, 32'h0);
      repeat (2) @(posedge pclk);
      chk("irq clear", {31'h0, irq}, 32'h0);
      apb(1'b1, ipr_pkg::H_WDATA, 32'h8);
      apb(1'b1, ipr_pkg::H_CTRL, 32'h8000_3081);
      apb(1'b0, ipr_pkg::H_ISTAT, 32'h0);
      chk("refused", rd, 32'h4);
      op(ipr_pkg::REG_STATE, 1'b1, 7'h30, 32'h0);
      chk("state", rd, 32'hc200_1234);
      op(ipr_pkg::REG_ADDR, 1'b0, 7'h30, 32'h8042);
      chk("addr", {25'h0, own_addr}, 32'h42);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("persist", {25'h0, own_addr}, 32'h42);
      op(ipr_pkg::REG_GUARD, 1'b1, 7'h42, 32'h0);
      chk("guard", rd, 32'h0);
      apb(1'b0, ipr_pkg::H_STAT, 32'h0);
      chk("unsupported", {31'h0, rd[2]}, 32'h1);
      op(ipr_pkg::REG_SCL, 1'b1, 7'h42, 32'h0);
      chk("scl fast plus", rd, ipr_pkg::KHZ_FMP);
      bus_mode <= ipr_pkg::MODE_FM;
      op(ipr_pkg::REG_SCL, 1'b1, 7'h42, 32'h0);
      chk("scl fast", rd, ipr_pkg::KHZ_FM);
      final_report();
   end
endmodule
